//--- design/interlock_teach_and_output_logic.sv
// Purpose: Teach-in sequencer, lock polarity and safety output enables
// Assumes: Reset marks a power-up; taught data lives in outside nonvolatile store
// Notes: Store record is read live and rewritten whole by a one-cycle write pulse
module interlock_teach_and_output_logic #(
   parameter longint unsigned TEACH_CYC   = interlock_pkg::TEACH_CYC,
   parameter longint unsigned REQ_CYC     = interlock_pkg::REQ_CYC,
   parameter longint unsigned INHIBIT_CYC = interlock_pkg::INHIBIT_CYC,
   parameter longint unsigned SLOW_CYC    = interlock_pkg::SLOW_CYC,
   parameter longint unsigned FAST_CYC    = interlock_pkg::FAST_CYC,
   parameter longint unsigned SHORT_CYC   = interlock_pkg::SHORT_CYC,
   parameter longint unsigned FAULT_CYC   = interlock_pkg::FAULT_CYC
) (
   // Clock and reset
   input  wire logic                              clock,
   input  wire logic                              rstn,
   input  wire logic                              clk_en,
   // Variant straps
   input  wire logic                              standard_coding,
   input  wire logic                              single_teach_variant,
   input  wire logic                              multi_teach_variant,
   input  wire logic                              energise_to_lock,
   input  wire logic                              unlock_drops_outputs,
   // Pins from outside
   input  wire logic                              lock_cmd,
   input  wire logic                              guard_closed,
   // Actuator sensing, same clock
   input  wire logic                              actuator_present,
   input  wire logic [interlock_pkg::CODE_W-1:0]  actuator_code,
   // Nonvolatile record, read side
   input  wire logic                              nv_code_valid,
   input  wire logic [interlock_pkg::CODE_W-1:0]  nv_code,
   input  wire logic                              nv_pending,
   input  wire logic [interlock_pkg::CODE_W-1:0]  nv_pend_code,
   input  wire logic                              nv_taught,
   input  wire logic                              nv_inhibit,
   // Nonvolatile record, write side
   output logic                                   nv_we,
   output logic                                   nv_wr_code_valid,
   output logic [interlock_pkg::CODE_W-1:0]       nv_wr_code,
   output logic                                   nv_wr_pending,
   output logic [interlock_pkg::CODE_W-1:0]       nv_wr_pend_code,
   output logic                                   nv_wr_taught,
   output logic                                   nv_wr_inhibit,
   // Solenoid and safety outputs
   output logic                                   solenoid_lock,
   output logic                                   safety_output_one,
   output logic                                   safety_output_two,
   // Indicators
   output logic                                   led_green,
   output logic                                   led_red,
   output logic                                   led_yellow
);
   localparam int TW = interlock_pkg::TMR_W;

   interlock_pkg::teach_state_t state_ff, nxt_state;
   logic [1:0]    sync1_ff, sync2_ff;
   logic [TW-1:0] tmr_ff, blk_ff, blk_period;
   logic [2:0]    flash_ff;
   logic          lock_in, closed_in, locked, matched, code_ok, teach_ok;
   logic          blink_on, blink_wrap, out_en, fault_done;
   logic [interlock_pkg::CODE_W-1:0] active_code;

   // Two-stage synchronisers for the pin inputs
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sync1_ff <= 2'h0;
         sync2_ff <= 2'h0;
      end else if (clk_en) begin
         sync1_ff <= {guard_closed, lock_cmd};
         sync2_ff <= sync1_ff;
      end
   end
   assign lock_in   = sync2_ff[0];
   assign closed_in = sync2_ff[1];

   // Command polarity selects locked sense
   assign locked = energise_to_lock ? lock_in : ~lock_in;

   // Code the device currently accepts
   always_comb begin
      active_code = interlock_pkg::STD_CODE;
      code_ok     = standard_coding;
      if (!standard_coding) begin
         active_code = nv_code;
         code_ok     = nv_code_valid;
      end
   end
   assign matched = actuator_present && code_ok && (actuator_code == active_code);

   // Single-teach refuses once paired; multi-teach always allows
   assign teach_ok = multi_teach_variant || (single_teach_variant && !nv_taught)
                     || (!single_teach_variant && !multi_teach_variant && !nv_taught);

   assign fault_done = blink_wrap && (flash_ff == interlock_pkg::FAULT_FLASHES - 3'h1);

   // Teach-in sequencer
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         interlock_pkg::ST_BOOT: begin
            // Inhibit restarts from zero after any power loss
            if (nv_inhibit && !standard_coding) begin
               nxt_state = interlock_pkg::ST_INHIBIT;
            end else if (actuator_present) begin
               if (standard_coding) begin
                  nxt_state = matched ? interlock_pkg::ST_RUN : interlock_pkg::ST_FAULT;
               end else if (nv_pending && actuator_code == nv_pend_code) begin
                  nxt_state = multi_teach_variant ? interlock_pkg::ST_INHIBIT
                                                  : interlock_pkg::ST_RUN;
               end else if (matched) begin
                  nxt_state = interlock_pkg::ST_RUN;
               end else if (teach_ok) begin
                  nxt_state = interlock_pkg::ST_TEACH;
               end else begin
                  nxt_state = interlock_pkg::ST_FAULT;
               end
            end
         end
         interlock_pkg::ST_RUN: nxt_state = interlock_pkg::ST_RUN;
         interlock_pkg::ST_TEACH: begin
            if (!actuator_present) begin
               nxt_state = interlock_pkg::ST_FAULT;
            end else if (tmr_ff >= TW'(TEACH_CYC - 1)) begin
               nxt_state = interlock_pkg::ST_REQUEST;
            end
         end
         interlock_pkg::ST_REQUEST: begin
            if (tmr_ff >= TW'(REQ_CYC - 1)) begin
               nxt_state = interlock_pkg::ST_FAULT;
            end
         end
         interlock_pkg::ST_FAULT: begin
            if (fault_done) begin
               nxt_state = interlock_pkg::ST_RUN;
            end
         end
         interlock_pkg::ST_INHIBIT: begin
            if (tmr_ff >= TW'(INHIBIT_CYC - 1) && matched) begin
               nxt_state = interlock_pkg::ST_RUN;
            end
         end
      endcase
   end

   // State register; reset is the power-up
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_ff <= interlock_pkg::ST_BOOT;
      end else if (clk_en) begin
         state_ff <= nxt_state;
      end
   end

   // Time in current state; saturates so long waits never wrap
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tmr_ff <= '0;
      end else if (clk_en) begin
         if (nxt_state != state_ff) begin
            tmr_ff <= '0;
         end else if (tmr_ff != '1) begin
            tmr_ff <= tmr_ff + TW'(1);
         end
      end
   end

   // Blink period per state
   always_comb begin
      blk_period = TW'(SLOW_CYC);
      if (state_ff == interlock_pkg::ST_REQUEST) begin
         blk_period = TW'(FAST_CYC);
      end else if (state_ff == interlock_pkg::ST_FAULT) begin
         blk_period = TW'(FAULT_CYC);
      end
   end
   assign blink_wrap = (blk_ff >= blk_period - TW'(1));

   // Blink phase counter, realigned on every state change
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         blk_ff <= '0;
      end else if (clk_en) begin
         if (nxt_state != state_ff || blink_wrap) begin
            blk_ff <= '0;
         end else begin
            blk_ff <= blk_ff + TW'(1);
         end
      end
   end

   // Red flash count in fault display
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flash_ff <= 3'h0;
      end else if (clk_en) begin
         if (state_ff != interlock_pkg::ST_FAULT) begin
            flash_ff <= 3'h0;
         end else if (blink_wrap) begin
            flash_ff <= flash_ff + 3'h1;
         end
      end
   end

   // Short on-time for 3 Hz, half period otherwise
   assign blink_on = (state_ff == interlock_pkg::ST_REQUEST) ? (blk_ff < TW'(SHORT_CYC))
                                                             : (blk_ff < (blk_period >> 1));

   // Nonvolatile writes: whole record rewritten on each event
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         nv_we            <= 1'b0;
         nv_wr_code_valid <= 1'b0;
         nv_wr_code       <= '0;
         nv_wr_pending    <= 1'b0;
         nv_wr_pend_code  <= '0;
         nv_wr_taught     <= 1'b0;
         nv_wr_inhibit    <= 1'b0;
      end else if (clk_en) begin
         nv_we            <= 1'b0;
         nv_wr_code_valid <= nv_code_valid;
         nv_wr_code       <= nv_code;
         nv_wr_pending    <= nv_pending;
         nv_wr_pend_code  <= nv_pend_code;
         nv_wr_taught     <= nv_taught;
         nv_wr_inhibit    <= nv_inhibit;
         if (state_ff == interlock_pkg::ST_BOOT && nxt_state != interlock_pkg::ST_BOOT
             && nxt_state != interlock_pkg::ST_FAULT && !standard_coding
             && nv_pending && actuator_present && actuator_code == nv_pend_code) begin
            // Commit only on renewed detection; old code is replaced
            nv_we            <= 1'b1;
            nv_wr_code_valid <= 1'b1;
            nv_wr_code       <= nv_pend_code;
            nv_wr_pending    <= 1'b0;
            nv_wr_taught     <= 1'b1;
            nv_wr_inhibit    <= multi_teach_variant;
         end else if (state_ff == interlock_pkg::ST_TEACH
                      && nxt_state == interlock_pkg::ST_REQUEST) begin
            // Code held pending until power returns
            nv_we           <= 1'b1;
            nv_wr_pending   <= 1'b1;
            nv_wr_pend_code <= actuator_code;
         end else if (state_ff == interlock_pkg::ST_REQUEST
                      && nxt_state == interlock_pkg::ST_FAULT) begin
            nv_we         <= 1'b1;
            nv_wr_pending <= 1'b0;
         end else if (state_ff == interlock_pkg::ST_INHIBIT
                      && nxt_state == interlock_pkg::ST_RUN) begin
            nv_we         <= 1'b1;
            nv_wr_inhibit <= 1'b0;
         end
      end
   end

   // Output enable: only in run with matched actuator and guard shut
   always_comb begin
      out_en = (state_ff == interlock_pkg::ST_RUN) && matched && closed_in;
      if (unlock_drops_outputs) begin
         out_en = out_en && locked;
      end
   end

   // Registered drive; one source feeds both channels so they never differ
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         solenoid_lock     <= 1'b0;
         safety_output_one <= 1'b0;
         safety_output_two <= 1'b0;
      end else if (clk_en) begin
         solenoid_lock     <= locked;
         safety_output_one <= out_en;
         safety_output_two <= out_en;
      end
   end

   // Indicator drive
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         led_green  <= 1'b0;
         led_red    <= 1'b0;
         led_yellow <= 1'b0;
      end else if (clk_en) begin
         led_green  <= 1'b1;
         led_red    <= 1'b0;
         led_yellow <= 1'b0;
         unique case (state_ff)
            interlock_pkg::ST_BOOT: led_green <= 1'b1;
            interlock_pkg::ST_RUN: begin
               if (matched && closed_in) begin
                  led_yellow <= locked ? 1'b1 : blink_on;
               end
            end
            interlock_pkg::ST_TEACH: begin
               led_green  <= 1'b0;
               led_red    <= 1'b1;
               led_yellow <= blink_on;
            end
            interlock_pkg::ST_REQUEST: begin
               led_green  <= 1'b0;
               led_red    <= 1'b1;
               led_yellow <= blink_on;
            end
            interlock_pkg::ST_FAULT: led_red <= blink_on;
            interlock_pkg::ST_INHIBIT: led_green <= blink_on;
         endcase
      end
   end
endmodule // interlock_teach_and_output_logic

//--- common/interlock_pkg.sv
// Purpose: Constants for the interlock teach-in and output logic
// Assumes: 200 MHz system clock
// Notes: Times are printed in their own unit; cycle counts derive from them
// Functional notes
// - Standard-coded units accept their matching actuator at once, no teach-in.
// - Actuator after power-up starts teach-in: green off, red on, yellow 1 Hz.
// - After 10 s of teach-in, yellow gives short 3 Hz blinks asking power-off.
// - No power-off within 5 min aborts teach-in with five red blinks.
// - After power returns, new code is stored only on renewed detection.
// - Single-teach variant refuses teach-in once a pairing is stored.
// - Multi-teach variant teaches any number of times, replacing the old code.
// - Multi-teach variant inhibits safety outputs ten minutes after teaching.
// - Green blinks until inhibit has expired and the new actuator is seen.
// - Power loss during inhibit restarts the full ten minutes at power-up.
// - Energise-to-unlock: command high unlocks, command low locks.
// - Energise-to-lock: command high locks, command low unlocks.
// - Unlock-drops-outputs variant disables both outputs while unlocked.
// - Unlock-drops-outputs variant re-enables outputs on relock with actuator in.
// - Open-drops-outputs variant drops outputs only when the guard opens.
package interlock_pkg;
   localparam int CODE_W = 16;
   localparam int TMR_W  = 40;
   // Arbitrary value for the factory standard code
   localparam logic [CODE_W-1:0] STD_CODE = 16'h5A_C3;
   localparam longint unsigned CLK_HZ = 200_000_000;
   // Times as printed
   localparam longint unsigned TEACH_S      = 10;
   localparam longint unsigned REQ_MIN      = 5;
   localparam longint unsigned INHIBIT_MIN  = 10;
   localparam longint unsigned SLOW_MS      = 1000;  // 1 Hz period
   localparam longint unsigned FAST_MS      = 333;   // 3 Hz period
   localparam longint unsigned SHORT_ON_MS  = 50;    // Brief flash width
   localparam longint unsigned FAULT_MS     = 500;   // Red flash period
   localparam logic [2:0]      FAULT_FLASHES = 3'h5;
   // Derived cycle counts
   localparam longint unsigned TEACH_CYC   = TEACH_S * CLK_HZ;
   localparam longint unsigned REQ_CYC     = REQ_MIN * 60 * CLK_HZ;
   localparam longint unsigned INHIBIT_CYC = INHIBIT_MIN * 60 * CLK_HZ;
   localparam longint unsigned SLOW_CYC    = SLOW_MS * (CLK_HZ / 1000);
   localparam longint unsigned FAST_CYC    = FAST_MS * (CLK_HZ / 1000);
   localparam longint unsigned SHORT_CYC   = SHORT_ON_MS * (CLK_HZ / 1000);
   localparam longint unsigned FAULT_CYC   = FAULT_MS * (CLK_HZ / 1000);
   typedef enum logic [2:0] {
      ST_BOOT, ST_RUN, ST_TEACH, ST_REQUEST, ST_FAULT, ST_INHIBIT
   } teach_state_t;
endpackage

//--- verif/interlock_monitor.sv
// Purpose: Port-level temporal checks on the interlock logic
// Assumes: One clock domain, async active-low reset
// Notes: Pin paths pass two sync stages, so pin windows run four cycles
module interlock_monitor #(
   parameter longint unsigned SLOW_CYC = interlock_pkg::SLOW_CYC
) (
   // Clock, reset and straps
   input wire logic clock, rstn, standard_coding, single_teach_variant, multi_teach_variant,
   input wire logic energise_to_lock, unlock_drops_outputs, clk_en,
   // Pins, actuator and stored codes
   input wire logic lock_cmd, guard_closed, actuator_present,
   input wire logic [interlock_pkg::CODE_W-1:0] actuator_code, nv_code, nv_pend_code,
   // Store record and design outputs
   input wire logic nv_pending, nv_taught, nv_inhibit, nv_we, nv_wr_pending,
   input wire logic [interlock_pkg::CODE_W-1:0] nv_wr_code, nv_wr_pend_code,
   input wire logic solenoid_lock, safety_output_one, safety_output_two, led_green
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int GW = interlock_pkg::TMR_W;
   logic [GW-1:0] grn_run_ff;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   // Unbroken green run in the inhibit; counted, a blink period is too long for a range
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         grn_run_ff <= '0;
      end else if (!led_green || !nv_inhibit) begin
         grn_run_ff <= '0;
      end else if (clk_en) begin
         grn_run_ff <= grn_run_ff + GW'(1);
      end
   end

   property p_pair; safety_output_one == safety_output_two; endproperty
   a_pair: assert property (p_pair)
      else $error("safety channels disagree");
   property p_drop; unlock_drops_outputs && $past(unlock_drops_outputs) && !solenoid_lock
      |-> !safety_output_one; endproperty
   a_drop: assert property (p_drop)
      else $error("outputs on while unlocked");
   property p_e2u; (!energise_to_lock && lock_cmd)[*4] |=> !solenoid_lock; endproperty
   a_e2u: assert property (p_e2u)
      else $error("command high did not unlock");
   property p_e2l; (energise_to_lock && !lock_cmd)[*4] |=> !solenoid_lock; endproperty
   a_e2l: assert property (p_e2l)
      else $error("command low did not unlock");
   property p_open; (!guard_closed)[*4] |=> !safety_output_one; endproperty
   a_open: assert property (p_open)
      else $error("outputs on with guard open");
   property p_inh; !standard_coding && nv_inhibit && $past(nv_inhibit) |-> !safety_output_one;
   endproperty
   a_inh: assert property (p_inh)
      else $error("outputs on during inhibit");
   property p_grn; nv_inhibit |-> grn_run_ff < GW'(SLOW_CYC); endproperty
   a_grn: assert property (p_grn)
      else $error("green not blinking in inhibit");
   property p_single; single_teach_variant && !multi_teach_variant && nv_taught && nv_we
      |-> nv_wr_code == nv_code && !nv_wr_pending; endproperty
   a_single: assert property (p_single)
      else $error("stored pairing altered");
   property p_commit; nv_we && nv_wr_code != nv_code |-> nv_pending && $past(actuator_present)
      && $past(actuator_code) == nv_pend_code; endproperty
   a_commit: assert property (p_commit)
      else $error("code stored without redetection");
   property p_pend; nv_we && nv_wr_pending && !nv_pending
      |-> nv_wr_pend_code == $past(actuator_code); endproperty
   a_pend: assert property (p_pend)
      else $error("pending code is not the actuator");
endmodule // interlock_monitor

bind interlock_teach_and_output_logic interlock_monitor #(.SLOW_CYC(SLOW_CYC)) mon (
   .clock, .rstn, .clk_en, .standard_coding, .single_teach_variant, .multi_teach_variant,
   .energise_to_lock, .unlock_drops_outputs, .lock_cmd, .guard_closed, .actuator_present,
   .actuator_code, .nv_code, .nv_pend_code, .nv_pending, .nv_taught, .nv_inhibit, .nv_we,
   .nv_wr_pending, .nv_wr_code, .nv_wr_pend_code, .solenoid_lock, .safety_output_one,
   .safety_output_two, .led_green);

//--- verif/nv_record_model.sv
// Purpose: Nonvolatile pairing record behind the interlock logic
// Assumes: Write pulse is one clock wide and carries the whole record
// Notes: No reset input, since a power cycle must not lose the pairing
module nv_record_model (
   // Clock and write side
   input  wire logic                             clock,
   input  wire logic                             nv_we,
   input  wire logic nv_wr_code_valid, nv_wr_pending, nv_wr_taught, nv_wr_inhibit,
   input  wire logic [interlock_pkg::CODE_W-1:0] nv_wr_code, nv_wr_pend_code,
   // Live record
   output logic      nv_code_valid, nv_pending, nv_taught, nv_inhibit,
   output logic      [interlock_pkg::CODE_W-1:0] nv_code, nv_pend_code
);
   timeunit 1ns;
   timeprecision 1ps;
   // Factory fresh blank record
   initial begin
      {nv_code_valid, nv_pending, nv_taught, nv_inhibit} = 4'h0;
      {nv_code, nv_pend_code} = 32'h0000_0000;
   end
   // Whole rewrite, so a new code replaces the old one outright
   always @(posedge clock) begin
      if (nv_we) begin
         {nv_code_valid, nv_pending, nv_taught, nv_inhibit} <=
            {nv_wr_code_valid, nv_wr_pending, nv_wr_taught, nv_wr_inhibit};
         nv_code      <= nv_wr_code;
         nv_pend_code <= nv_wr_pend_code;
      end
   end
endmodule // nv_record_model

//--- verif/interlock_teach_and_output_logic_tb.sv
// Purpose: Directed bench for teach-in, lock polarity and output enables
// Assumes: Shortened counts; store record survives each power cycle
// Notes: Inputs change and outputs are sampled on the falling edge
module interlock_teach_and_output_logic_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] CA = 16'h1234, CB = 16'h0F0F, CC = 16'hC0DE;
   localparam int WE = 0, OUT = 1, LCK = 2, GRN = 3, RED = 4, YEL = 5;
   logic clock, rstn, clk_en, standard_coding, single_teach_variant, multi_teach_variant;
   logic energise_to_lock, unlock_drops_outputs, lock_cmd, guard_closed, actuator_present;
   logic nv_code_valid, nv_pending, nv_taught, nv_inhibit, nv_we, nv_wr_code_valid;
   logic nv_wr_pending, nv_wr_taught, nv_wr_inhibit, solenoid_lock, safety_output_one;
   logic safety_output_two, led_green, led_red, led_yellow;
   logic [15:0] actuator_code, nv_code, nv_pend_code, nv_wr_code, nv_wr_pend_code;
   logic [5:0]  obs;
   string       nm [6] = '{"nv_we", "outputs", "lock", "green", "red", "yellow"};
   int          err_count = 0;
   int          checks_done = 0;
   int          cyc = 0;

   assign obs = {led_yellow, led_red, led_green, solenoid_lock, safety_output_one, nv_we};

   interlock_teach_and_output_logic #(.TEACH_CYC(40), .REQ_CYC(80), .INHIBIT_CYC(100),
      .SLOW_CYC(8), .FAST_CYC(6), .SHORT_CYC(2), .FAULT_CYC(8)) DUT (
      .clock, .rstn, .clk_en, .standard_coding, .single_teach_variant, .multi_teach_variant,
      .energise_to_lock, .unlock_drops_outputs, .lock_cmd, .guard_closed, .actuator_present,
      .actuator_code, .nv_code_valid, .nv_code, .nv_pending, .nv_pend_code, .nv_taught,
      .nv_inhibit, .nv_we, .nv_wr_code_valid, .nv_wr_code, .nv_wr_pending, .nv_wr_pend_code,
      .nv_wr_taught, .nv_wr_inhibit, .solenoid_lock, .safety_output_one, .safety_output_two,
      .led_green, .led_red, .led_yellow);
   nv_record_model nvm (.clock, .nv_we, .nv_wr_code_valid, .nv_wr_pending, .nv_wr_taught,
      .nv_wr_inhibit, .nv_wr_code, .nv_wr_pend_code, .nv_code_valid, .nv_pending,
      .nv_taught, .nv_inhibit, .nv_code, .nv_pend_code);

   // Free-running 200 MHz clock
   initial begin
      clock = 1'h0;
      forever #2.5 clock = ~clock;
   end
   // Hang guard, well above the roughly 800 cycles the run needs
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         close_out();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Bounded wait for an output level, then compare
   task automatic await(input int i, input logic v, input int lim);
      int n;
      n = 0;
      while (obs[i] !== v && n < lim) begin
         @(negedge clock);
         n++;
      end
      check(nm[i], 16'(obs[i]), 16'(v));
   endtask
   // Level must hold for every sampled cycle
   task automatic hold(input int i, input logic v, input int n);
      logic bad;
      bad = 1'h0;
      repeat (n) begin
         @(negedge clock);
         if (obs[i] !== v) bad = 1'h1;
      end
      check(nm[i], 16'(bad), 16'h0000);
   endtask
   // Count moves to a level; shows blinking rather than a steady lamp
   task automatic edges(input int i, input logic v, input int n, input int exp);
      int k;
      logic last;
      k = 0;
      last = obs[i];
      repeat (n) begin
         @(negedge clock);
         if (obs[i] === v && last !== v) k++;
         last = obs[i];
      end
      check(nm[i], 16'(k), 16'(exp));
   endtask
   // Supply off and back on
   task automatic power_cycle();
      @(negedge clock);
      rstn = 1'h0;
      repeat (5) @(negedge clock);
      rstn = 1'h1;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      {rstn, standard_coding, single_teach_variant, energise_to_lock, lock_cmd} = 5'h0;
      {clk_en, multi_teach_variant, unlock_drops_outputs, guard_closed} = 4'hF;
      actuator_present = 1'h1;
      actuator_code = interlock_pkg::STD_CODE;
      standard_coding = 1'h1;
      repeat (5) @(negedge clock);
      rstn = 1'h1;
      await(OUT, 1'h1, 20);
      check("output two", 32'(safety_output_two), 32'h1);
      // Enable low freezes the outputs although the code no longer matches
      clk_en = 1'h0;
      actuator_code = CA;
      hold(OUT, 1'h1, 8);
      clk_en = 1'h1;
      await(OUT, 1'h0, 4);
      actuator_code = interlock_pkg::STD_CODE;
      await(OUT, 1'h1, 4);
      check(nm[LCK], 16'(solenoid_lock), 16'h0001);
      lock_cmd = 1'h1;
      await(LCK, 1'h0, 6);
      check(nm[OUT], 16'(safety_output_one), 16'h0000);
      lock_cmd = 1'h0;
      await(OUT, 1'h1, 6);
      energise_to_lock = 1'h1;
      await(LCK, 1'h0, 6);
      lock_cmd = 1'h1;
      await(LCK, 1'h1, 6);
      unlock_drops_outputs = 1'h0;
      lock_cmd = 1'h0;
      await(LCK, 1'h0, 6);
      hold(OUT, 1'h1, 6);
      guard_closed = 1'h0;
      await(OUT, 1'h0, 6);
      {guard_closed, unlock_drops_outputs, energise_to_lock} = 3'h6;
      // Teach code A, then power off during the request
      standard_coding = 1'h0;
      actuator_code = CA;
      power_cycle();
      repeat (4) @(negedge clock);
      check("red green", {led_red, led_green}, 16'h0002);
      edges(YEL, 1'h1, 24, 3);
      await(WE, 1'h1, 20);
      check("pending", {nv_wr_pending, nv_wr_pend_code}, {1'h1, CA});
      repeat (2) @(negedge clock);
      edges(YEL, 1'h1, 24, 4);
      power_cycle();
      await(WE, 1'h1, 10);
      check("commit", {nv_wr_code_valid, nv_wr_inhibit, nv_wr_code}, {2'h3, CA});
      check("taught", 32'(nv_wr_taught), 32'h1);
      hold(OUT, 1'h0, 60);
      edges(GRN, 1'h1, 24, 3);
      power_cycle();
      hold(OUT, 1'h0, 90);
      await(OUT, 1'h1, 40);
      check(nm[GRN], 16'(led_green), 16'h0001);
      // Reteach with code B; code A must stop matching
      actuator_code = CB;
      power_cycle();
      await(WE, 1'h1, 60);
      power_cycle();
      await(WE, 1'h1, 10);
      check("new code", nv_wr_code, CB);
      await(OUT, 1'h1, 130);
      actuator_code = CA;
      await(OUT, 1'h0, 6);
      // Request left unanswered runs into the actuator fault
      actuator_code = CC;
      power_cycle();
      await(WE, 1'h1, 60);
      repeat (2) @(negedge clock);
      await(WE, 1'h1, 90);
      check("pending clear", 16'(nv_wr_pending), 16'h0000);
      edges(RED, 1'h0, 60, 5);
      check("kept code", nv_code, CB);
      // Actuator pulled out mid teach-in ends in the actuator fault, nothing stored
      power_cycle();
      repeat (4) @(negedge clock);
      actuator_present = 1'h0;
      edges(RED, 1'h0, 60, 5);
      check("no pending", 32'(nv_pending), 32'h0);
      actuator_present = 1'h1;
      // Single variant with a stored pairing refuses a new actuator
      {single_teach_variant, multi_teach_variant} = 2'h2;
      power_cycle();
      edges(RED, 1'h0, 60, 5);
      check("kept code", {nv_pending, nv_code}, {1'h0, CB});
      close_out();
   end
endmodule // interlock_teach_and_output_logic_tb
